// ### common/dpe_pkg.sv
package dpe_pkg;
  // Register offsets from the debug base
  localparam logic [15:0] OFF_CTRL = 16'h0000;
  localparam logic [15:0] OFF_PIDS = 16'h0004;
  localparam logic [15:0] OFF_BUF_LO = 16'h0008;
  localparam logic [15:0] OFF_BUF_HI = 16'h000C;
  localparam logic [15:0] OFF_TARGET = 16'h0010;
  localparam logic [15:0] REG_SPAN = 16'h0014;
  // Debug base field default in config space
  localparam logic [12:0] BASE_RST = 13'h00E0;
  // Control and status bit positions
  localparam int CS_LEN_LSB = 0;
  localparam int CS_DIR = 4;
  localparam int CS_GO = 5;
  localparam int CS_ERR = 6;
  localparam int CS_EXC_LSB = 7;
  localparam int CS_INUSE = 10;
  localparam int CS_DONE = 16;
  localparam int CS_ENABLED = 28;
  localparam int CS_OWNER = 30;
  // Target address fields and reset values
  localparam int TA_ENDP_LSB = 0;
  localparam int TA_ADDR_LSB = 8;
  localparam logic [3:0] ENDP_RST = 4'h1;
  localparam logic [6:0] ADDR_RST = 7'h7F;
  // Exception codes
  localparam logic [2:0] EXC_NONE = 3'h0;
  localparam logic [2:0] EXC_XACT = 3'h1;
  localparam logic [2:0] EXC_PORT = 3'h2;
  // Handshake PID sent after good IN data
  localparam logic [7:0] PID_ACK = 8'hD2;
  localparam logic [3:0] MAX_BYTES = 4'h8;
  // Response timeout
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESP_TIMEOUT_NS = 2000;
  localparam int RESP_TIMEOUT_CYC = (RESP_TIMEOUT_NS / CLK_PERIOD_NS < 1) ? 1 :
      RESP_TIMEOUT_NS / CLK_PERIOD_NS;

  // Transaction states
  typedef enum logic [6:0] {
    ST_IDLE = 7'b000_0001,
    ST_TOKEN = 7'b000_0010,
    ST_DOUT = 7'b000_0100,
    ST_WHS = 7'b000_1000,
    ST_WDATA = 7'b001_0000,
    ST_ACK = 7'b010_0000,
    ST_DONE = 7'b100_0000
  } dpe_state_type;

  // Byte toward the link layer
  typedef struct packed {
    logic last;
    logic [7:0] data;
  } dpe_txbyte_type;

  // Byte from the link layer
  typedef struct packed {
    logic err;
    logic last;
    logic [7:0] data;
  } dpe_rxbyte_type;
endpackage

// ### hw/dpe_engine.sv
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// Two-entry buffer between engine and link
module dpe_two_entry_buf #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem_r [0:DEPTH-1];
  logic [PW-1:0] wrPtr_r;
  logic [PW-1:0] rdPtr_r;
  logic [PW:0] count_r;
  wire logic push = inValid && inReady;
  wire logic pop = outValid && outReady;

  // Honest full and empty
  assign inReady = (count_r != (PW+1)'(DEPTH));
  assign outValid = (count_r != '0);
  assign outData = mem_r[rdPtr_r];

  // Pointers and occupancy
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_r <= '0;
      rdPtr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) wrPtr_r <= (wrPtr_r == PW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
      if (pop) rdPtr_r <= (rdPtr_r == PW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
      count_r <= count_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Storage
  always_ff @(posedge clk) begin
    if (push) mem_r[wrPtr_r] <= inData;
  end
endmodule // dpe_two_entry_buf

////////////////////////////////////////////////////////////////////////////////
// Debug port transaction engine
module dpe_engine (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [12:0] debugBaseConfig,
  input wire logic memSel,
  input wire logic memWr,
  input wire logic [15:0] memAddr,
  input wire logic [3:0] memBe,
  input wire logic [31:0] memWdata,
  output logic memHit,
  output logic [31:0] memRdata,
  input wire logic portEnabled,
  input wire logic portEnableChange,
  input wire logic portSuspended,
  input wire logic portInReset,
  output logic ownerTake,
  output logic ownerForce,
  output logic txValid,
  input wire logic txReady,
  output dpe_pkg::dpe_txbyte_type txByte,
  input wire logic rxValid,
  input wire dpe_pkg::dpe_rxbyte_type rxByte
);
  dpe_pkg::dpe_state_type state_r, state_nxt;
  logic [3:0] len_r;
  logic dir_r, go_r, err_r, inUse_r, done_r, enabled_r, owner_r;
  logic [2:0] exc_r, resExc_r;
  logic [7:0] tokenPid_r, sendPid_r, capPid_r;
  logic [3:0] endp_r;
  logic [6:0] addr_r;
  logic [7:0] dataBuf_r [0:7];
  logic [3:0] txIdx_r, rxCnt_r;
  logic rxFirst_r;
  logic [15:0] waitCnt_r;
  logic bufInReady;

  //////////////////////////////////////////////////////////////////////////////
  // Address decode against the config-space base
  wire logic [15:0] offset = memAddr - {3'b000, debugBaseConfig};
  wire logic [2:0] wordIdx = offset[4:2];
  assign memHit = memSel && (offset < dpe_pkg::REG_SPAN);
  wire logic wrHit = memHit && memWr;
  wire logic wrCtrl = wrHit && (wordIdx == dpe_pkg::OFF_CTRL[4:2]);
  wire logic wrPids = wrHit && (wordIdx == dpe_pkg::OFF_PIDS[4:2]);
  wire logic wrBufLo = wrHit && (wordIdx == dpe_pkg::OFF_BUF_LO[4:2]);
  wire logic wrBufHi = wrHit && (wordIdx == dpe_pkg::OFF_BUF_HI[4:2]);
  wire logic wrTarget = wrHit && (wordIdx == dpe_pkg::OFF_TARGET[4:2]);

  // Control word write effects
  wire logic launch = wrCtrl && memBe[0] && memWdata[dpe_pkg::CS_GO]
      && state_r == dpe_pkg::ST_IDLE;
  wire logic finish = (state_r == dpe_pkg::ST_DONE);
  wire logic doneClr = wrCtrl && memBe[2] && memWdata[dpe_pkg::CS_DONE];
  wire logic enWr = wrCtrl && memBe[3];
  wire logic portBad = portSuspended || portInReset;

  //////////////////////////////////////////////////////////////////////////////
  // Outgoing byte selection
  wire logic [7:0] tokB1 = {endp_r[0], addr_r};
  wire logic [7:0] tokB2 = {5'h00, endp_r[3:1]};
  wire logic [7:0] tokByte = (txIdx_r == 4'h0) ? tokenPid_r :
      (txIdx_r == 4'h1) ? tokB1 : tokB2;
  wire logic [7:0] doutByte = (txIdx_r == 4'h0) ? sendPid_r :
      dataBuf_r[txIdx_r[2:0] - 3'h1];
  wire logic doutLast = (txIdx_r == len_r);
  wire logic pushValid = (state_r == dpe_pkg::ST_TOKEN) || (state_r == dpe_pkg::ST_DOUT)
      || (state_r == dpe_pkg::ST_ACK);
  wire logic pushFire = pushValid && bufInReady;
  wire logic [7:0] pushData = (state_r == dpe_pkg::ST_TOKEN) ? tokByte :
      (state_r == dpe_pkg::ST_DOUT) ? doutByte : dpe_pkg::PID_ACK;
  wire logic pushLast = (state_r == dpe_pkg::ST_TOKEN) ? (txIdx_r == 4'h2) :
      (state_r == dpe_pkg::ST_DOUT) ? doutLast : 1'b1;
  wire dpe_pkg::dpe_txbyte_type pushByte = '{last: pushLast, data: pushData};

  // Stall-safe path to the link
  dpe_two_entry_buf #(.WIDTH(9), .DEPTH(2)) txBuf (
    .clk(clk),
    .rst_b(rst_b),
    .inValid(pushValid),
    .inReady(bufInReady),
    .inData(pushByte),
    .outValid(txValid),
    .outReady(txReady),
    .outData(txByte)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Received byte classification
  wire logic pidBad = (rxByte.data[7:4] != ~rxByte.data[3:0]);
  wire logic pidHs = (rxByte.data[1:0] == 2'b10);
  wire logic rxWait = (state_r == dpe_pkg::ST_WHS) || (state_r == dpe_pkg::ST_WDATA);
  wire logic timeoutHit = rxWait && (waitCnt_r == 16'(dpe_pkg::RESP_TIMEOUT_CYC - 1));
  wire logic rxTake = rxWait && rxValid;
  wire logic rxPid = rxTake && rxFirst_r;
  wire logic rxData = rxTake && !rxFirst_r && (state_r == dpe_pkg::ST_WDATA);
  wire logic rxOver = rxData && (rxCnt_r == dpe_pkg::MAX_BYTES);
  wire logic rxFail = rxTake && (rxByte.err || (rxFirst_r && pidBad) || rxOver);

  // Next state of a transaction
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      dpe_pkg::ST_IDLE: if (launch) state_nxt = dpe_pkg::ST_TOKEN;
      dpe_pkg::ST_TOKEN: if (pushFire && pushLast) begin
        state_nxt = dir_r ? dpe_pkg::ST_DOUT : dpe_pkg::ST_WDATA;
      end
      dpe_pkg::ST_DOUT: if (pushFire && pushLast) state_nxt = dpe_pkg::ST_WHS;
      dpe_pkg::ST_WHS: if (rxTake || timeoutHit) state_nxt = dpe_pkg::ST_DONE;
      dpe_pkg::ST_WDATA: begin
        if (timeoutHit || rxFail) state_nxt = dpe_pkg::ST_DONE;
        else if (rxPid && pidHs) state_nxt = dpe_pkg::ST_DONE;
        else if (rxTake && rxByte.last) state_nxt = dpe_pkg::ST_ACK;
      end
      dpe_pkg::ST_ACK: if (pushFire) state_nxt = dpe_pkg::ST_DONE;
      dpe_pkg::ST_DONE: state_nxt = dpe_pkg::ST_IDLE;
      default: state_nxt = dpe_pkg::ST_IDLE;
    endcase
    if (portBad && !(state_r inside {dpe_pkg::ST_IDLE, dpe_pkg::ST_DONE})) begin
      state_nxt = dpe_pkg::ST_DONE;
    end
  end

  // Transaction sequencing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= dpe_pkg::ST_IDLE;
      txIdx_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      if (state_nxt != state_r) txIdx_r <= 4'h0;
      else if (pushFire) txIdx_r <= txIdx_r + 4'h1;
    end
  end

  // Receive counters and response timer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rxFirst_r <= 1'b1;
      rxCnt_r <= 4'h0;
      waitCnt_r <= 16'h0000;
    end else begin
      waitCnt_r <= (!rxWait || rxTake) ? 16'h0000 : waitCnt_r + 16'h0001;
      if (launch) rxFirst_r <= 1'b1;
      else if (rxTake) rxFirst_r <= 1'b0;
      if (launch) rxCnt_r <= 4'h0;
      else if (rxData && !rxOver) rxCnt_r <= rxCnt_r + 4'h1;
    end
  end

  // Exception class gathered during the run
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) resExc_r <= dpe_pkg::EXC_NONE;
    else if (launch) resExc_r <= dpe_pkg::EXC_NONE;
    else if (portBad && !(state_r inside {dpe_pkg::ST_IDLE, dpe_pkg::ST_DONE})) begin
      resExc_r <= dpe_pkg::EXC_PORT;
    end else if ((rxFail || timeoutHit) && resExc_r == dpe_pkg::EXC_NONE) begin
      resExc_r <= dpe_pkg::EXC_XACT;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control and status word
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      len_r <= 4'h0;
      dir_r <= 1'b0;
      go_r <= 1'b0;
      err_r <= 1'b0;
      exc_r <= dpe_pkg::EXC_NONE;
      inUse_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (wrCtrl && memBe[0]) begin
        len_r <= memWdata[dpe_pkg::CS_LEN_LSB +: 4];
        dir_r <= memWdata[dpe_pkg::CS_DIR];
      end
      if (wrCtrl && memBe[1]) inUse_r <= memWdata[dpe_pkg::CS_INUSE];
      if (launch) go_r <= 1'b1;
      if (finish) begin
        go_r <= 1'b0;
        done_r <= 1'b1;
        err_r <= (resExc_r != dpe_pkg::EXC_NONE);
        exc_r <= resExc_r;
        if (!dir_r) len_r <= rxCnt_r;
      end else if (doneClr) begin
        done_r <= 1'b0;
      end
    end
  end

  // Port enable and ownership override
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enabled_r <= 1'b0;
      owner_r <= 1'b0;
    end else begin
      if (portEnableChange) enabled_r <= 1'b0;
      else if (enWr && !memWdata[dpe_pkg::CS_ENABLED]) enabled_r <= 1'b0;
      else if (enWr && portEnabled) enabled_r <= 1'b1;
      if (enWr) owner_r <= memWdata[dpe_pkg::CS_OWNER];
    end
  end
  assign ownerForce = owner_r;
  assign ownerTake = enWr && memWdata[dpe_pkg::CS_OWNER];

  // PID and target registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tokenPid_r <= 8'h00;
      sendPid_r <= 8'h00;
      capPid_r <= 8'h00;
      endp_r <= dpe_pkg::ENDP_RST;
      addr_r <= dpe_pkg::ADDR_RST;
    end else begin
      if (wrPids && memBe[0]) tokenPid_r <= memWdata[7:0];
      if (wrPids && memBe[1]) sendPid_r <= memWdata[15:8];
      if (rxPid) capPid_r <= rxByte.data;
      if (wrTarget && memBe[0]) endp_r <= memWdata[dpe_pkg::TA_ENDP_LSB +: 4];
      if (wrTarget && memBe[1]) addr_r <= memWdata[dpe_pkg::TA_ADDR_LSB +: 7];
    end
  end

  // Data buffer, one byte lane each
  genvar gb;
  generate
    for (gb = 0; gb < 8; gb++) begin : gBuf
      wire logic busWr = (gb < 4) ? (wrBufLo && memBe[gb % 4]) :
          (wrBufHi && memBe[gb % 4]);
      wire logic engWr = rxData && !rxOver && (rxCnt_r[2:0] == 3'(gb));
      always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) dataBuf_r[gb] <= 8'h00;
        else if (engWr) dataBuf_r[gb] <= rxByte.data;
        else if (busWr) dataBuf_r[gb] <= memWdata[(gb % 4) * 8 +: 8];
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Read data mux
  wire logic [31:0] ctrlWord = {1'b0, owner_r, 1'b0, enabled_r, 11'h000, done_r, 5'h00,
      inUse_r, exc_r, err_r, go_r, dir_r, len_r};
  wire logic [31:0] pidsWord = {8'h00, capPid_r, sendPid_r, tokenPid_r};
  wire logic [31:0] targetWord = {17'h0_0000, addr_r, 4'h0, endp_r};
  wire logic [31:0] rdWord =
      (wordIdx == dpe_pkg::OFF_CTRL[4:2]) ? ctrlWord :
      (wordIdx == dpe_pkg::OFF_PIDS[4:2]) ? pidsWord :
      (wordIdx == dpe_pkg::OFF_BUF_LO[4:2]) ?
      {dataBuf_r[3], dataBuf_r[2], dataBuf_r[1], dataBuf_r[0]} :
      (wordIdx == dpe_pkg::OFF_BUF_HI[4:2]) ?
      {dataBuf_r[7], dataBuf_r[6], dataBuf_r[5], dataBuf_r[4]} : targetWord;

  // Registered read answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) memRdata <= 32'h0000_0000;
    else if (memHit && !memWr) memRdata <= rdWord;
    else memRdata <= 32'h0000_0000;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence sLaunch;
    launch ##1 (state_r == dpe_pkg::ST_TOKEN);
  endsequence
  sequence sTokenPid;
    pushFire && state_r == dpe_pkg::ST_TOKEN && txIdx_r == 4'h0;
  endsequence

  a_go_done_together: assert property ($rose(done_r) |-> $fell(go_r))
    else $error("start bit not cleared with completion");
  a_err_matches_exc: assert property ($rose(done_r) |-> err_r == (exc_r != 3'h0))
    else $error("error flag disagrees with exception code");
  a_read_len_max: assert property ($rose(done_r) && !dir_r |-> len_r <= 4'h8)
    else $error("read length above eight");
  a_done_write_clear: assert property (doneClr && !finish |=> !done_r)
    else $error("completion not cleared by write of one");
  a_exc_read_only: assert property (!finish |=> $stable(exc_r))
    else $error("exception code changed outside completion");
  a_enable_needs_port: assert property ($rose(enabled_r) |-> $past(portEnabled))
    else $error("debug enable set while port disabled");
  a_enable_change_clr: assert property (portEnableChange |=> !enabled_r)
    else $error("debug enable kept after port enable change");
  a_token_packet_id_sent: assert property (sTokenPid |-> pushData == tokenPid_r)
    else $error("token packet PID wrong");
  a_token_target: assert property (pushFire && state_r == dpe_pkg::ST_TOKEN
      && txIdx_r == 4'h1 |-> pushData == {endp_r[0], addr_r})
    else $error("token address byte wrong");
  a_zero_len_pkt: assert property (pushFire && state_r == dpe_pkg::ST_DOUT && txIdx_r == 4'h0
      |-> pushData == sendPid_r && pushLast == (len_r == 4'h0))
    else $error("data packet start wrong");
  a_launch_token: assert property (sLaunch ##0 !portBad |-> ##[1:3] pushValid)
    else $error("launch did not start token");
  a_dir_select: assert property (state_r == dpe_pkg::ST_TOKEN && pushFire && pushLast
      && !portBad |=> state_r == (dir_r ? dpe_pkg::ST_DOUT : dpe_pkg::ST_WDATA))
    else $error("direction not followed after token");
endmodule // dpe_engine

// ### verif/dpe_console_model.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Debug console on the far side of the byte link
module dpe_console_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic txValid,
  output logic txReady,
  input wire dpe_pkg::dpe_txbyte_type txByte,
  output logic rxValid,
  output dpe_pkg::dpe_rxbyte_type rxByte
);
  logic slow = 1'b0;
  int frames = 0;
  logic [7:0] seen[$];

  initial begin
    rxValid = 1'b0;
    rxByte = '0;
  end

  // Log every accepted byte; stall every other cycle when slow
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txReady <= 1'b0;
    end else begin
      if (txValid && txReady) begin
        seen.push_back(txByte.data);
        if (txByte.last) begin
          frames++;
        end
      end
      txReady <= #1 (slow ? ~txReady : 1'b1);
    end
  end

  // One received byte after a gap; idle line shows the inverse, not stale data
  task automatic send(input int gap, input logic [7:0] d, input logic lst, input logic bad);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    #1;
    rxByte = {bad, lst, d};
    rxValid = 1'b1;
    @(posedge clk);
    #1;
    rxValid = 1'b0;
    rxByte = ~rxByte;
  endtask
endmodule // dpe_console_model

// ### verif/tb_usb_debug_port_engine.sv
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench for the debug port engine
module tb_usb_debug_port_engine;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [12:0] base = dpe_pkg::BASE_RST;
  logic memSel = 1'b0;
  logic memWr = 1'b0;
  logic [15:0] memAddr = '0;
  logic [3:0] memBe = '0;
  logic [31:0] memWdata = '0;
  logic memHit, ownerTake, ownerForce, txValid, txReady, rxValid;
  logic [31:0] memRdata, rdv;
  logic portEnabled = 1'b0;
  logic portEnableChange = 1'b0;
  logic portSuspended = 1'b0;
  logic portInReset = 1'b0;
  logic hitv, takev;
  dpe_pkg::dpe_txbyte_type txByte;
  dpe_pkg::dpe_rxbyte_type rxByte;
  int errTotal = 0;
  int totalChecks = 0;
  int cycles = 0;

  dpe_engine i_dut (.clk(clk), .rst_b(rst_b), .debugBaseConfig(base), .memSel(memSel),
    .memWr(memWr), .memAddr(memAddr), .memBe(memBe), .memWdata(memWdata), .memHit(memHit),
    .memRdata(memRdata), .portEnabled(portEnabled), .portEnableChange(portEnableChange),
    .portSuspended(portSuspended), .portInReset(portInReset), .ownerTake(ownerTake),
    .ownerForce(ownerForce), .txValid(txValid), .txReady(txReady), .txByte(txByte),
    .rxValid(rxValid), .rxByte(rxByte));
  dpe_console_model i_con (.clk(clk), .rst_b(rst_b), .txValid(txValid), .txReady(txReady),
    .txByte(txByte), .rxValid(rxValid), .rxByte(rxByte));

  // Clock and hang guard
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errTotal++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus and link helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      errTotal++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    memSel = 1'b1;
    memWr = w;
    memAddr = a;
    memWdata = d;
    memBe = be;
    @(posedge clk);
    hitv = memHit;
    takev = ownerTake;
    #1;
    memSel = 1'b0;
    rdv = memRdata;
    @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [15:0] off);
    bus(1'b0, {3'b0, base} + off, 32'h0000_0000, 4'hF);
  endtask
  task automatic wr(input logic [15:0] off, input logic [31:0] d);
    bus(1'b1, {3'b0, base} + off, d, 4'hF);
  endtask
  task automatic wait_done;
    int n;
    n = 0;
    rd(dpe_pkg::OFF_CTRL);
    while (rdv[16] !== 1'b1 && n < 400) begin
      rd(dpe_pkg::OFF_CTRL);
      n++;
    end
  endtask
  task automatic wait_frames(input int k);
    int n;
    n = 0;
    while (i_con.frames < k && n < 400) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic chk_tx(input logic [7:0] exp[$]);
    chk("tx count", exp.size(), i_con.seen.size());
    foreach (exp[i]) begin
      if (i < i_con.seen.size()) begin
        chk("tx byte", exp[i], i_con.seen[i]);
      end
    end
    i_con.seen.delete();
    i_con.frames = 0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic reset_regs;
    rd(dpe_pkg::OFF_CTRL);
    chk("ctrl reset", 32'h0000_0000, rdv);
    rd(dpe_pkg::OFF_TARGET);
    chk("target reset", 32'h0000_7F01, rdv);
    bus(1'b0, 16'h0000, 32'h0000_0000, 4'hF);
    chk("mem base hit", 32'h0000_0000, {31'b0, hitv});
    rd(dpe_pkg::REG_SPAN);
    chk("unmapped", 32'h0000_0000, {hitv, rdv[30:0]});
    bus(1'b1, {3'b0, base} + dpe_pkg::OFF_BUF_LO, 32'hAABB_CCDD, 4'b0010);
    bus(1'b1, {3'b0, base} + dpe_pkg::OFF_BUF_HI, 32'h1100_0000, 4'b1000);
    rd(dpe_pkg::OFF_BUF_LO);
    chk("buf lane lo", 32'h0000_CC00, rdv);
    rd(dpe_pkg::OFF_BUF_HI);
    chk("buf lane hi", 32'h1100_0000, rdv);
    base = 13'h0200;
    rd(dpe_pkg::OFF_TARGET);
    chk("moved base", 32'h0000_7F01, rdv);
    base = dpe_pkg::BASE_RST;
    $display("test reset_regs done");
  endtask
  task automatic read_in;
    wr(dpe_pkg::OFF_PIDS, 32'h0000_0069);
    wr(dpe_pkg::OFF_TARGET, 32'h0000_0502);
    wr(dpe_pkg::OFF_CTRL, 32'h0000_0020);
    wait_frames(1);
    i_con.send(0, 8'h4B, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      i_con.send(0, 8'h80 + i[7:0], i == 7, 1'b0);
    end
    wait_done();
    chk("read ctrl", 32'h0001_0008, rdv);
    rd(dpe_pkg::OFF_PIDS);
    chk("read pid", 32'h004B_0069, rdv);
    rd(dpe_pkg::OFF_BUF_LO);
    chk("read buf lo", 32'h8382_8180, rdv);
    rd(dpe_pkg::OFF_BUF_HI);
    chk("read buf hi", 32'h8786_8584, rdv);
    chk_tx('{8'h69, 8'h05, 8'h01, dpe_pkg::PID_ACK});
    wr(dpe_pkg::OFF_CTRL, 32'h0001_0000);
    $display("test read_in done");
  endtask
  task automatic rx_error;
    wr(dpe_pkg::OFF_CTRL, 32'h0000_0020);
    wait_frames(1);
    i_con.send(3, 8'h4B, 1'b0, 1'b0);
    i_con.send(0, 8'h00, 1'b1, 1'b1);
    wait_done();
    chk("err ctrl", 32'h0001_00C0, rdv & 32'h0001_03E0);
    wr(dpe_pkg::OFF_CTRL, 32'h0001_0000);
    rd(dpe_pkg::OFF_CTRL);
    chk("exc kept", 32'h0000_00C0, rdv & 32'h0001_03E0);
    i_con.seen.delete();
    i_con.frames = 0;
    $display("test rx_error done");
  endtask
  task automatic write_out;
    i_con.slow = 1'b1;
    wr(dpe_pkg::OFF_PIDS, 32'h0000_C3E1);
    wr(dpe_pkg::OFF_BUF_LO, 32'h4433_2211);
    wr(dpe_pkg::OFF_CTRL, 32'h0000_0033);
    wait_frames(2);
    i_con.send(2, 8'hD2, 1'b1, 1'b0);
    wait_done();
    chk("write ctrl", 32'h0001_0013, rdv);
    rd(dpe_pkg::OFF_PIDS);
    chk("write pid", 32'h00D2_C3E1, rdv);
    chk_tx('{8'hE1, 8'h05, 8'h01, 8'hC3, 8'h11, 8'h22, 8'h33});
    wr(dpe_pkg::OFF_CTRL, 32'h0000_0013);
    rd(dpe_pkg::OFF_CTRL);
    chk("done hold", 32'h0001_0013, rdv);
    wr(dpe_pkg::OFF_CTRL, 32'h0001_0013);
    rd(dpe_pkg::OFF_CTRL);
    chk("done clear", 32'h0000_0013, rdv);
    i_con.slow = 1'b0;
    $display("test write_out done");
  endtask
  task automatic zero_len;
    wr(dpe_pkg::OFF_CTRL, 32'h0000_0030);
    wait_frames(2);
    i_con.send(0, 8'h5A, 1'b1, 1'b0);
    wait_done();
    chk("zlp ctrl", 32'h0001_0010, rdv);
    rd(dpe_pkg::OFF_PIDS);
    chk("nak pid", 32'h005A_C3E1, rdv);
    chk_tx('{8'hE1, 8'h05, 8'h01, 8'hC3});
    wr(dpe_pkg::OFF_CTRL, 32'h0001_0000);
    $display("test zero_len done");
  endtask
  task automatic read_short;
    wr(dpe_pkg::OFF_CTRL, 32'h0000_0020);
    wait_frames(1);
    i_con.send(0, 8'h1E, 1'b1, 1'b0);
    wait_done();
    chk("in hs ctrl", 32'h0001_0000, rdv);
    rd(dpe_pkg::OFF_PIDS);
    chk("in hs pid", 32'h001E_C3E1, rdv);
    chk_tx('{8'hE1, 8'h05, 8'h01});
    wr(dpe_pkg::OFF_CTRL, 32'h0001_0000);
    wr(dpe_pkg::OFF_CTRL, 32'h0000_0020);
    wait_done();
    chk("timeout ctrl", 32'h0001_00C0, rdv);
    chk_tx('{8'hE1, 8'h05, 8'h01});
    wr(dpe_pkg::OFF_CTRL, 32'h0001_0000);
    $display("test read_short done");
  endtask
  task automatic port_fault;
    for (int k = 0; k < 2; k++) begin
      portSuspended = (k == 0);
      portInReset = (k == 1);
      wr(dpe_pkg::OFF_CTRL, 32'h0000_0030);
      wait_done();
      chk("port exc", 32'h0001_0140, rdv & 32'h0001_03E0);
      portSuspended = 1'b0;
      portInReset = 1'b0;
      wr(dpe_pkg::OFF_CTRL, 32'h0001_0000);
      repeat (20) @(posedge clk);
      #1;
      i_con.seen.delete();
      i_con.frames = 0;
    end
    $display("test port_fault done");
  endtask
  task automatic control_bits;
    wr(dpe_pkg::OFF_CTRL, 32'h1000_0400);
    rd(dpe_pkg::OFF_CTRL);
    chk("enable refused", 32'h0000_0400, rdv & 32'h5000_0400);
    portEnabled = 1'b1;
    wr(dpe_pkg::OFF_CTRL, 32'h1000_0400);
    rd(dpe_pkg::OFF_CTRL);
    chk("enable set", 32'h1000_0400, rdv & 32'h5000_0400);
    portEnableChange = 1'b1;
    @(posedge clk);
    #1;
    portEnableChange = 1'b0;
    rd(dpe_pkg::OFF_CTRL);
    chk("enable lost", 32'h0000_0400, rdv & 32'h5000_0400);
    wr(dpe_pkg::OFF_CTRL, 32'h1000_0000);
    wr(dpe_pkg::OFF_CTRL, 32'h0000_0000);
    rd(dpe_pkg::OFF_CTRL);
    chk("enable cleared", 32'h0000_0000, rdv & 32'h5000_0400);
    wr(dpe_pkg::OFF_CTRL, 32'h4000_0000);
    chk("owner take", 32'h0000_0001, {31'b0, takev});
    rd(dpe_pkg::OFF_CTRL);
    chk("owner bit", 32'h4000_0001, {rdv & 32'h4000_0000} | {31'b0, ownerForce});
    $display("test control_bits done");
  endtask

  // Verdict and end of run
  task automatic close_out;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence; each launch waits for the previous completion
  initial begin
    repeat (2) @(posedge clk);
    #1;
    rst_b = 1'b1;
    reset_regs();
    read_in();
    rx_error();
    write_out();
    zero_len();
    read_short();
    port_fault();
    control_bits();
    close_out();
  end
endmodule // tb_usb_debug_port_engine
